// ### logic/dgrs_top.sv
// file: global request, status and configuration logic of the dma controller
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps

// Behaviour
// RQ1 - raw error status readable, one bit/channel
// RQ2 - activity view mirrors channel enable bits
// RQ3 - activity bit clears when transfer finishes
// RQ4 - written one raises software burst request
// RQ5 - written one raises software single request
// RQ6 - sixteen-bit last-burst request field
// RQ7 - sixteen-bit last-single request field
// RQ8 - request bits held until completion; zeros ignored
// RQ9 - reads show sources currently requesting; reads return the software request bits only
// RQ10 - peripheral line or software bit both served
// RQ11 - config bit0 global enable, resets zero
// RQ12 - config bit1 sets master one order
// RQ13 - config bit2 sets master two order
// RQ14 - both masters little-endian after reset
// RQ15 - sync register bypasses synchroniser when set
// RQ16 - sync register resets to all zeros
// RQ17 - four sixteen-bit peripheral request groups
// RQ18 - peripheral waits while clear response high
// RQ19 - foreign-clock peripherals keep synchronisation on
// RQ20 - peripheral synchronises responses if needed
// RQ21 - software writes zero to reserved bits
// RQ22 - error clear write of one clears status
// RQ23 - activity bit set cycle after enable
module dgrs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dgrs_pkg::dgrs_req_t periph_req,
  input wire logic [7:0] channel_enable_set,
  input wire logic [7:0] channel_done,
  input wire logic [7:0] channel_error,
  input wire logic [15:0] burst_done,
  input wire logic [15:0] single_done,
  input wire logic [15:0] last_burst_done,
  input wire logic [15:0] last_single_done,
  output dgrs_pkg::dgrs_req_t req_to_engine,
  output dgrs_pkg::dgrs_cfg_t cfg_out
);

  ////////////////////////////////////////////////////////////////////////////
  // exact word offsets only; unaligned addresses fall through to unmapped
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [15:0] sticky_req(input logic [15:0] cur, input logic [15:0] set,
                                             input logic [15:0] done);
    // new set wins over completion in the same cycle
    sticky_req = (cur & ~done) | set;
  endfunction

  function automatic logic [15:0] pick_sync(input logic [15:0] raw, input logic [15:0] synced,
                                            input logic [15:0] bypass);
    pick_sync = (raw & bypass) | (synced & ~bypass);
  endfunction

  function automatic logic [15:0] wr_field(input logic en, input logic [15:0] data);
    wr_field = en ? data : dgrs_pkg::SRC_ZERO;
  endfunction

  // undefined upper bits read as zero
  function automatic logic [31:0] zx8(input logic [7:0] v);
    zx8 = {24'h000000, v};
  endfunction

  function automatic logic [31:0] zx16(input logic [15:0] v);
    zx16 = {16'h0000, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] raw_err_q;
  logic [7:0] raw_err_d;
  logic [7:0] act_ch_q;
  logic [7:0] act_ch_d;
  logic [15:0] sw_burst_q;
  logic [15:0] sw_burst_d;
  logic [15:0] sw_single_q;
  logic [15:0] sw_single_d;
  logic [15:0] sw_lburst_q;
  logic [15:0] sw_lburst_d;
  logic [15:0] sw_lsingle_q;
  logic [15:0] sw_lsingle_d;
  logic [2:0] cfg_q;
  logic [2:0] cfg_d;
  logic [15:0] sync_q;
  logic [15:0] sync_d;
  dgrs_pkg::dgrs_req_t sync1_q;
  dgrs_pkg::dgrs_req_t sync2_q;
  logic [15:0] req_burst_q;
  logic [15:0] req_burst_d;
  logic [15:0] req_single_q;
  logic [15:0] req_single_d;
  logic [15:0] req_lburst_q;
  logic [15:0] req_lburst_d;
  logic [15:0] req_lsingle_q;
  logic [15:0] req_lsingle_d;
  dgrs_pkg::dgrs_cfg_t cfg_out_d;
  logic [15:0] wr_burst;
  logic [15:0] wr_single;
  logic [15:0] wr_lburst;
  logic [15:0] wr_lsingle;
  logic [7:0] wr_errclr;
  logic [31:0] rdata_d;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // single-cycle access phase: pready follows every setup cycle
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = setup & ~pwrite;

  assign wr_burst = wr_field(wr_acc & hit(paddr, dgrs_pkg::SW_BURST_OFS),
                             pwdata[15:0]); // RQ4
  assign wr_single = wr_field(wr_acc & hit(paddr, dgrs_pkg::SW_SINGLE_OFS),
                              pwdata[15:0]); // RQ5
  assign wr_lburst = wr_field(wr_acc & hit(paddr, dgrs_pkg::SW_LBURST_OFS),
                              pwdata[15:0]); // RQ6
  assign wr_lsingle = wr_field(wr_acc & hit(paddr, dgrs_pkg::SW_LSINGLE_OFS),
                               pwdata[15:0]); // RQ7
  assign wr_errclr = (wr_acc && hit(paddr, dgrs_pkg::ERR_CLR_OFS)) ? pwdata[7:0] :
                     dgrs_pkg::CH_ZERO; // RQ22

  ////////////////////////////////////////////////////////////////////////////
  // error status: channels set, written ones clear; a new error wins
  always_comb begin
    raw_err_d = (raw_err_q & ~wr_errclr) | channel_error; // RQ1 RQ22
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_err_q <= dgrs_pkg::CH_ZERO;
    end else begin
      raw_err_q <= raw_err_d;
    end
  end

  // activity view: enable sets, completion clears; enable wins
  always_comb begin
    act_ch_d = (act_ch_q & ~channel_done) | channel_enable_set; // RQ2 RQ3 RQ23
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ch_q <= dgrs_pkg::CH_ZERO;
    end else begin
      act_ch_q <= act_ch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software requests stay until the engine reports completion
  always_comb begin
    sw_burst_d = sticky_req(sw_burst_q, wr_burst, burst_done); // RQ8
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_burst_q <= dgrs_pkg::SRC_ZERO;
    end else begin
      sw_burst_q <= sw_burst_d;
    end
  end

  always_comb begin
    sw_single_d = sticky_req(sw_single_q, wr_single, single_done); // RQ8
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_single_q <= dgrs_pkg::SRC_ZERO;
    end else begin
      sw_single_q <= sw_single_d;
    end
  end

  always_comb begin
    sw_lburst_d = sticky_req(sw_lburst_q, wr_lburst, last_burst_done); // RQ8
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_lburst_q <= dgrs_pkg::SRC_ZERO;
    end else begin
      sw_lburst_q <= sw_lburst_d;
    end
  end

  always_comb begin
    sw_lsingle_d = sticky_req(sw_lsingle_q, wr_lsingle, last_single_done); // RQ8
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_lsingle_q <= dgrs_pkg::SRC_ZERO;
    end else begin
      sw_lsingle_q <= sw_lsingle_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // undefined upper bits are dropped on write
  always_comb begin
    cfg_d = cfg_q;
    if (wr_acc && hit(paddr, dgrs_pkg::CFG_OFS)) begin
      cfg_d = pwdata[2:0]; // RQ11 RQ12 RQ13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= dgrs_pkg::CFG_RESET; // RQ11 RQ14
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_comb begin
    sync_d = sync_q;
    if (wr_acc && hit(paddr, dgrs_pkg::SYNC_OFS)) begin
      sync_d = pwdata[15:0]; // RQ15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= dgrs_pkg::SYNC_RESET; // RQ16
    end else begin
      sync_q <= sync_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser on every peripheral request line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
    end else begin
      sync1_q <= periph_req; // RQ17
    end
  end

  // only the second stage reads the first, so no metastable value spreads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync2_q <= '0;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bypass skips both stages, yet the output stage stays registered
  always_comb begin
    req_burst_d = pick_sync(periph_req.burst, sync2_q.burst, sync_q) | sw_burst_q; // RQ10 RQ15
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_burst_q <= dgrs_pkg::SRC_ZERO;
    end else begin
      req_burst_q <= req_burst_d;
    end
  end

  always_comb begin
    req_single_d = pick_sync(periph_req.single, sync2_q.single, sync_q) | sw_single_q; // RQ10
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_single_q <= dgrs_pkg::SRC_ZERO;
    end else begin
      req_single_q <= req_single_d;
    end
  end

  always_comb begin
    req_lburst_d = pick_sync(periph_req.last_burst, sync2_q.last_burst, sync_q)
                   | sw_lburst_q; // RQ10
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_lburst_q <= dgrs_pkg::SRC_ZERO;
    end else begin
      req_lburst_q <= req_lburst_d;
    end
  end

  always_comb begin
    req_lsingle_d = pick_sync(periph_req.last_single, sync2_q.last_single, sync_q)
                    | sw_lsingle_q; // RQ10
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_lsingle_q <= dgrs_pkg::SRC_ZERO;
    end else begin
      req_lsingle_q <= req_lsingle_d;
    end
  end

  assign req_to_engine = {req_burst_q, req_single_q, req_lburst_q, req_lsingle_q};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cfg_out_d.enable = cfg_q[dgrs_pkg::CFG_EN_BIT]; // RQ11
    cfg_out_d.master_one_byte_order = cfg_q[dgrs_pkg::CFG_M1_BIT]; // RQ12
    cfg_out_d.master_two_byte_order = cfg_q[dgrs_pkg::CFG_M2_BIT]; // RQ13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_out <= '0;
    end else begin
      cfg_out <= cfg_out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data captured in setup so it stands during access
  always_comb begin
    rdata_d = 32'h00000000;
    mapped = 1'b1;
    if (hit(paddr, dgrs_pkg::RAW_ERR_OFS)) begin
      rdata_d = zx8(raw_err_q); // RQ1
    end else if (hit(paddr, dgrs_pkg::ACT_CH_OFS)) begin
      rdata_d = zx8(act_ch_q); // RQ2
    end else if (hit(paddr, dgrs_pkg::SW_BURST_OFS)) begin
      rdata_d = zx16(sw_burst_q); // RQ9
    end else if (hit(paddr, dgrs_pkg::SW_SINGLE_OFS)) begin
      rdata_d = zx16(sw_single_q); // RQ9
    end else if (hit(paddr, dgrs_pkg::SW_LBURST_OFS)) begin
      rdata_d = zx16(sw_lburst_q); // RQ9
    end else if (hit(paddr, dgrs_pkg::SW_LSINGLE_OFS)) begin
      rdata_d = zx16(sw_lsingle_q); // RQ9
    end else if (hit(paddr, dgrs_pkg::CFG_OFS)) begin
      rdata_d = zx8({5'h00, cfg_q});
    end else if (hit(paddr, dgrs_pkg::SYNC_OFS)) begin
      rdata_d = zx16(sync_q);
    end else if (hit(paddr, dgrs_pkg::ERR_CLR_OFS)) begin
      // write-only clear register reads as zero
      rdata_d = 32'h00000000;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_acc) begin
      prdata <= rdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

endmodule // dgrs_top

// ### logic/dgrs_pkg.sv
// package: register map, field positions and carriers for the dma global control block
package dgrs_pkg;
  localparam int NUM_CH = 8;
  localparam int NUM_SRC = 16;
  localparam logic [11:0] ERR_CLR_OFS = 12'h010;
  localparam logic [11:0] RAW_ERR_OFS = 12'h018;
  localparam logic [11:0] ACT_CH_OFS = 12'h01C;
  localparam logic [11:0] SW_BURST_OFS = 12'h020;
  localparam logic [11:0] SW_SINGLE_OFS = 12'h024;
  localparam logic [11:0] SW_LBURST_OFS = 12'h028;
  localparam logic [11:0] SW_LSINGLE_OFS = 12'h02C;
  localparam logic [11:0] CFG_OFS = 12'h030;
  localparam logic [11:0] SYNC_OFS = 12'h034;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_M1_BIT = 1;
  localparam int CFG_M2_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [15:0] SYNC_RESET = 16'h0000;
  localparam logic [15:0] SRC_ZERO = 16'h0000;
  localparam logic [7:0] CH_ZERO = 8'h00;

  // one bundle per request type: burst, single, last burst, last single
  typedef struct packed {
    logic [15:0] burst;
    logic [15:0] single;
    logic [15:0] last_burst;
    logic [15:0] last_single;
  } dgrs_req_t;

  typedef struct packed {
    logic enable;
    logic master_one_byte_order;
    logic master_two_byte_order;
  } dgrs_cfg_t;
endpackage

// ### testbench/dgrs_periph_model.sv
// peripheral request line model for the dma global block
`timescale 1ns/10ps
module dgrs_periph_model (
  input wire logic pclk,
  input wire logic slow,
  input wire dgrs_pkg::dgrs_req_t cmd,
  output dgrs_pkg::dgrs_req_t req
);
  dgrs_pkg::dgrs_req_t d_q;
  always_ff @(posedge pclk) d_q <= cmd;
  // same clock as the block, so a slow answer is just one stage more
  always_ff @(posedge pclk) req <= slow ? d_q : cmd;
endmodule // dgrs_periph_model

// ### testbench/dgrs_monitor.sv
// port checker for the dma global block
`timescale 1ns/10ps
module dgrs_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dgrs_pkg::dgrs_req_t req_to_engine,
  input wire dgrs_pkg::dgrs_cfg_t cfg_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_q;
  logic [2:0] cfg_q;
  wire cfg_wr = psel && penable && pwrite && paddr == 12'h030;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_q <= 1'b0;
    else wr_q <= cfg_wr;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_q <= 3'h0;
    else if (cfg_wr) cfg_q <= {pwdata[0], pwdata[1], pwdata[2]};
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr(a); psel && penable && pwrite && paddr == a; endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_one: assert property (pready |=> !pready) else $error("ready too long");
  a_err_in_ready: assert property (pslverr |-> pready) else $error("stray err");
  a_unmapped_err: assert property (s_setup ##0 paddr > 12'h034 |=> pslverr)
    else $error("unmapped not refused");
  a_cfg_takes: assert property (s_wr(12'h030) |=> ##[0:1] cfg_out == cfg_q)
    else $error("cfg not applied");
  a_cfg_quiet: assert property (!wr_q && !$past(wr_q) && !$past(wr_q, 2) |-> $stable(cfg_out))
    else $error("cfg moved");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved");
  a_sw_reaches: assert property (s_wr(12'h020) ##0 pwdata[0] |-> ##[1:3] req_to_engine.burst[0])
    else $error("sw burst lost");
endmodule // dgrs_monitor
bind dgrs_top dgrs_monitor u_dgrs_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .req_to_engine(req_to_engine), .cfg_out(cfg_out));

// ### testbench/testbench.sv
// self-checking bench for the dma global request block
`timescale 1ns/10ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, se;
  logic [11:0] paddr = 0, a;
  logic [31:0] pwdata = 0, rs = 32'hC5AF, r, prdata;
  logic pready;
  logic [7:0] ens = 0, chd = 0, cer = 0;
  logic [15:0] dn[4] = '{default: 16'h0000}, v;
  dgrs_pkg::dgrs_req_t cmd = 0, preq, eng;
  dgrs_pkg::dgrs_cfg_t cfg;
  int miscompares = 0, n_checks = 0, exp[4];
  dgrs_top u_dgrs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(se), .periph_req(preq), .channel_enable_set(ens), .channel_done(chd),
    .channel_error(cer), .burst_done(dn[0]), .single_done(dn[1]), .last_burst_done(dn[2]),
    .last_single_done(dn[3]), .req_to_engine(eng), .cfg_out(cfg));
  dgrs_periph_model u_dgrs_periph_model (.pclk(pclk), .slow(slow), .cmd(cmd), .req(preq));
  always #5 pclk = ~pclk;
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    apb(0, ad, 0);
    chk(r, e);
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    for (int i = 'h18; i <= 'h34; i += 4) rd(12'(i), 0);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h030, 32'(i));
      rd(12'h030, 32'(i));
      chk(32'({<<{cfg}}), 32'(i));
    end
    rs = lf(rs);
    apb(1, 12'h034, {16'h0, rs[15:0]});
    rd(12'h034, {16'h0, rs[15:0]});
    $display("config done");
    for (int m = 0; m < 2; m++) begin
      apb(1, 12'h034, m ? 0 : 32'hFFFF);
      v = 16'h8001 >> m;
      @(posedge pclk) begin slow <= m[0]; cmd <= {4{v}}; end
      repeat (6) @(posedge pclk);
      chk(eng[63:32], {2{v}});
      chk(eng[31:0], {2{v}});
      @(posedge pclk) cmd <= 0;
      repeat (6) @(posedge pclk);
      chk(eng[63:32] | eng[31:0], 0);
    end
    $display("peripheral requests done");
    for (int k = 0; k < 4; k++) begin
      rs = lf(rs);
      exp[k] = {rs[15:1], 1'b1};
      a = 12'(32'h20 + 4 * k);
      apb(1, a, exp[k]);
      apb(1, a, 0);
      rd(a, exp[k]);
      chk(32'(eng[63 - 16 * k -: 16]), exp[k]);
      @(posedge pclk) dn[k] <= 16'h00FF;
      @(posedge pclk) dn[k] <= 0;
      exp[k] &= 32'hFF00;
      rd(a, exp[k]);
    end
    $display("software requests done");
    rs = lf(rs);
    @(posedge pclk) begin cer <= rs[7:0]; ens <= rs[15:8]; end
    @(posedge pclk) begin cer <= 0; ens <= 0; chd <= rs[11:8]; end
    @(posedge pclk) chd <= 0;
    rd(12'h018, 32'(rs[7:0]));
    rd(12'h01C, 32'({rs[15:12], 4'h0}));
    apb(1, 12'h010, 32'(rs[3:0]));
    rd(12'h018, 32'({rs[7:4], 4'h0}));
    apb(1, 12'h040, 32'hFFFF);
    chk(32'(se), 1);
    rd(12'h040, 0);
    $display("status and refusal done");
    test_done;
  end
endmodule // testbench
